//--- src/tesd_axis.sv
// One axis of transient detection: threshold compare and debounce counter.
`timescale 1ns/1ps
`default_nettype none
`include "tesd_defines.svh"

module tesd_axis #(
    parameter int ACC_W = 14,
    parameter int THS_W = 7,
    parameter int CNT_W = 8
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  sample_in,
    input  wire logic signed [ACC_W-1:0] accel_in,
    input  wire logic [THS_W-1:0]      ths_in,
    input  wire tesd_pkg::tesd_fs_t    full_scale_in,
    input  wire logic                  low_noise_in,
    input  wire logic                  enable_in,
    input  wire tesd_pkg::tesd_db_mode_t mode_in,
    input  wire logic [CNT_W-1:0]      count_in,
    output logic                       event_out,
    output logic                       pol_out
);
    import tesd_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             fire;
        logic             pol;
    } tesd_axis_state_t;

    tesd_axis_state_t st_q;
    tesd_axis_state_t st_d;

    logic [ACC_W-1:0] mag;
    logic [1:0]       shift;
    logic [31:0]      lim;
    logic [31:0]      mag_c;
    logic [31:0]      lhs;
    logic [31:0]      rhs;
    logic             over;
    logic             cond;
    logic [CNT_W-1:0] inc;

    // ------------------------------------------------------------------------
    // Threshold compare
    // ------------------------------------------------------------------------
    always_comb begin
        mag   = accel_in[ACC_W-1] ? ACC_W'(-accel_in) : ACC_W'(accel_in);
        shift = (full_scale_in == TESD_FS_RSVD) ? `TESD_FS_MAX_SHIFT : 2'(full_scale_in);
        // Low-noise mode caps the measurable magnitude at four g.
        lim   = (`TESD_LOW_NOISE_G * `TESD_COUNTS_PER_G) >> shift;
        mag_c = 32'(mag);
        if (low_noise_in && (mag_c > lim)) begin
            mag_c = lim;
        end
        // Threshold LSB is fixed in milli-g, sample LSB follows the range.
        lhs  = 32'(mag_c * `TESD_MG_PER_G);
        rhs  = 32'((32'(ths_in) * `TESD_MG_PER_LSB * `TESD_COUNTS_PER_G) >> shift);
        over = lhs > rhs;
        cond = over && enable_in;
        inc  = (st_q.cnt < count_in) ? CNT_W'(st_q.cnt + 1'b1) : count_in;
    end

    // ------------------------------------------------------------------------
    // Debounce counter
    // ------------------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        st_d.fire = 1'b0;
        if (sample_in) begin
            if (cond) begin
                st_d.cnt = inc;
                if (inc >= count_in) begin
                    st_d.fire = 1'b1;
                    st_d.pol  = accel_in[ACC_W-1];
                end
            end else if (mode_in == TESD_DB_CLEAR) begin
                st_d.cnt = '0;
            end else if (st_q.cnt != '0) begin
                st_d.cnt = CNT_W'(st_q.cnt - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign event_out = st_q.fire;
    assign pol_out   = st_q.pol;

endmodule

`default_nettype wire

//--- src/tesd_defines.svh
// Offsets, field positions, reset values and scaling constants of the transient event block.
`ifndef TESD_DEFINES_SVH
`define TESD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TESD_OFF_CFG        8'h1D
`define TESD_OFF_STATUS     8'h1E
`define TESD_OFF_THS        8'h1F
`define TESD_OFF_COUNT      8'h20

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TESD_RST_CFG        8'h00
`define TESD_RST_STATUS     8'h00
`define TESD_RST_THS        8'h00
`define TESD_RST_COUNT      8'h00
`define TESD_RDATA_NONE     8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TESD_CFG_LATCH      4
`define TESD_CFG_ZEN        3
`define TESD_CFG_YEN        2
`define TESD_CFG_XEN        1
`define TESD_THS_MODE       7
`define TESD_THS_MSB        6
`define TESD_ST_ANY         6
`define TESD_ST_ZEF         5
`define TESD_ST_ZPOL        4
`define TESD_ST_YEF         3
`define TESD_ST_YPOL        2
`define TESD_ST_XEF         1
`define TESD_ST_XPOL        0

// ----------------------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------------------
`define TESD_MG_PER_LSB     32'd63
`define TESD_MG_PER_G       32'd1000
`define TESD_COUNTS_PER_G   32'd4096
`define TESD_LOW_NOISE_G    32'd4
`define TESD_FS_MAX_SHIFT   2'h2

`endif

//--- src/tesd_pkg.sv
// Types shared by the transient event status and threshold block.
package tesd_pkg;

    typedef enum logic {
        TESD_DB_DECREMENT,
        TESD_DB_CLEAR
    } tesd_db_mode_t;

    typedef enum logic [1:0] {
        TESD_FS_2G,
        TESD_FS_4G,
        TESD_FS_8G,
        TESD_FS_RSVD
    } tesd_fs_t;

endpackage

//--- src/tesd_top.sv
// Transient event status register, threshold register and per-axis detection.
//
// What this block does
// - Read-only status at 0x1E, resets zero.
// - Bit 6 is OR of axis flags.
// - Axis flags set after debounced threshold crossing.
// - Direction bit: zero positive, one negative.
// - Latch on: freeze flags at trigger.
// - Latch off: later events keep updating bits.
// - Only a status read clears flags.
// - Mode zero: decrement counter when condition false.
// - Mode one: clear counter when condition false.
// - Seven-bit threshold, fixed 63 mg steps.
// - Low-noise limits measurement range to 4 g.
// - Per-axis thresholds selectable for Y, Z.
// - Disabled axis never raises its flag.
// - Count register gives minimum debounce periods.
`timescale 1ns/1ps
`default_nettype none
`include "tesd_defines.svh"

module tesd_top #(
    parameter int ACC_W = 14,
    parameter int THS_W = 7,
    parameter int CNT_W = 8
) (
    input  wire logic                    mclk_in,
    input  wire logic                    resetn_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    input  wire logic [7:0]              reg_wdata_in,
    output logic [7:0]                   reg_rdata_out,
    input  wire logic                    sample_valid_in,
    input  wire logic signed [ACC_W-1:0] accel_x_in,
    input  wire logic signed [ACC_W-1:0] accel_y_in,
    input  wire logic signed [ACC_W-1:0] accel_z_in,
    input  wire logic                    per_axis_ths_en_in,
    input  wire logic [THS_W-1:0]        y_ths_in,
    input  wire logic [THS_W-1:0]        z_ths_in,
    input  wire tesd_pkg::tesd_fs_t      full_scale_select_in,
    input  wire logic                    low_noise_in,
    output logic                         any_axis_event_out
);
    import tesd_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ths;
        logic [7:0] count;
        logic [2:0] flag;
        logic [2:0] pol;
        logic [7:0] rdata;
    } tesd_top_state_t;

    tesd_top_state_t st_q;
    tesd_top_state_t st_d;

    logic [1:0]       rst_sync_q;
    logic             rst_n;
    logic [2:0]       axis_event;
    logic [2:0]       axis_pol;
    logic [2:0]       axis_en;
    logic [THS_W-1:0] ths_x;
    logic [THS_W-1:0] ths_y;
    logic [THS_W-1:0] ths_z;
    tesd_db_mode_t    db_mode;
    logic [7:0]       status;
    logic             frozen;
    logic             rd_status;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    function automatic logic [7:0] status_byte(input logic [2:0] flag, input logic [2:0] pol);
        logic [7:0] b;
        b                = 8'h00;
        b[`TESD_ST_ANY]  = |flag;
        b[`TESD_ST_ZEF]  = flag[2];
        b[`TESD_ST_ZPOL] = pol[2];
        b[`TESD_ST_YEF]  = flag[1];
        b[`TESD_ST_YPOL] = pol[1];
        b[`TESD_ST_XEF]  = flag[0];
        b[`TESD_ST_XPOL] = pol[0];
        status_byte      = b;
    endfunction

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    // Assertion is immediate; release is taken through two flip-flops.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Axis configuration
    // ------------------------------------------------------------------------
    always_comb begin
        axis_en = {st_q.cfg[`TESD_CFG_ZEN], st_q.cfg[`TESD_CFG_YEN], st_q.cfg[`TESD_CFG_XEN]};
        db_mode = st_q.ths[`TESD_THS_MODE] ? TESD_DB_CLEAR : TESD_DB_DECREMENT;
        ths_x   = st_q.ths[`TESD_THS_MSB:0];
        ths_y   = per_axis_ths_en_in ? y_ths_in : st_q.ths[`TESD_THS_MSB:0];
        ths_z   = per_axis_ths_en_in ? z_ths_in : st_q.ths[`TESD_THS_MSB:0];
    end

    tesd_axis #(
        .ACC_W (ACC_W),
        .THS_W (THS_W),
        .CNT_W (CNT_W)
    ) u_axis_x (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .sample_in     (sample_valid_in),
        .accel_in      (accel_x_in),
        .ths_in        (ths_x),
        .full_scale_in (full_scale_select_in),
        .low_noise_in  (low_noise_in),
        .enable_in     (axis_en[0]),
        .mode_in       (db_mode),
        .count_in      (CNT_W'(st_q.count)),
        .event_out     (axis_event[0]),
        .pol_out       (axis_pol[0])
    );

    tesd_axis #(
        .ACC_W (ACC_W),
        .THS_W (THS_W),
        .CNT_W (CNT_W)
    ) u_axis_y (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .sample_in     (sample_valid_in),
        .accel_in      (accel_y_in),
        .ths_in        (ths_y),
        .full_scale_in (full_scale_select_in),
        .low_noise_in  (low_noise_in),
        .enable_in     (axis_en[1]),
        .mode_in       (db_mode),
        .count_in      (CNT_W'(st_q.count)),
        .event_out     (axis_event[1]),
        .pol_out       (axis_pol[1])
    );

    tesd_axis #(
        .ACC_W (ACC_W),
        .THS_W (THS_W),
        .CNT_W (CNT_W)
    ) u_axis_z (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .sample_in     (sample_valid_in),
        .accel_in      (accel_z_in),
        .ths_in        (ths_z),
        .full_scale_in (full_scale_select_in),
        .low_noise_in  (low_noise_in),
        .enable_in     (axis_en[2]),
        .mode_in       (db_mode),
        .count_in      (CNT_W'(st_q.count)),
        .event_out     (axis_event[2]),
        .pol_out       (axis_pol[2])
    );

    // ------------------------------------------------------------------------
    // Status flags and register access
    // ------------------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        status    = status_byte(st_q.flag, st_q.pol);
        rd_status = reg_rd_in && reg_hit(reg_addr_in, `TESD_OFF_STATUS);
        // With the latch on, the first trigger freezes the bits until read.
        frozen    = st_q.cfg[`TESD_CFG_LATCH] && (|st_q.flag) && !rd_status;

        if (rd_status) begin
            st_d.flag = 3'h0;
        end
        // An event in the clearing cycle still lands: set wins over clear.
        if (!frozen) begin
            for (int i = 0; i < 3; i++) begin
                if (axis_event[i]) begin
                    st_d.flag[i] = 1'b1;
                    st_d.pol[i]  = axis_pol[i];
                end
            end
        end

        if (reg_wr_in) begin
            if (reg_hit(reg_addr_in, `TESD_OFF_CFG)) begin
                st_d.cfg = reg_wdata_in;
            end
            if (reg_hit(reg_addr_in, `TESD_OFF_THS)) begin
                st_d.ths = reg_wdata_in;
            end
            if (reg_hit(reg_addr_in, `TESD_OFF_COUNT)) begin
                st_d.count = reg_wdata_in;
            end
        end

        if (reg_rd_in) begin
            case (reg_addr_in)
                `TESD_OFF_CFG: begin
                    st_d.rdata = st_q.cfg;
                end
                `TESD_OFF_STATUS: begin
                    st_d.rdata = status;
                end
                `TESD_OFF_THS: begin
                    st_d.rdata = st_q.ths;
                end
                `TESD_OFF_COUNT: begin
                    st_d.rdata = st_q.count;
                end
                default: begin
                    st_d.rdata = `TESD_RDATA_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q.cfg   <= `TESD_RST_CFG;
            st_q.ths   <= `TESD_RST_THS;
            st_q.count <= `TESD_RST_COUNT;
            st_q.flag  <= 3'h0;
            st_q.pol   <= 3'h0;
            st_q.rdata <= `TESD_RST_STATUS;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out      = st_q.rdata;
    assign any_axis_event_out = |st_q.flag;

endmodule

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench of the transient event status and threshold block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import tesd_pkg::*;
    logic              mclk_in = 1'h0;
    logic              resetn = 1'h0;
    logic [7:0]        addr, wdata, rdata;
    logic              wr, rd, any;
    logic              sv = 1'h0;
    logic signed [13:0] ax = 14'h0000, ay = 14'h0000, az = 14'h0000;
    logic              pae = 1'h0;
    logic              ln = 1'h0;
    logic [6:0]        yth = 7'h00, zth = 7'h00;
    tesd_fs_t          fs = TESD_FS_8G;
    int                n_mismatch = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    always #50 mclk_in = ~mclk_in;

    tesd_host u_host (.clk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
                      .wdata_out(wdata));

    tesd_top uut (.mclk_in(mclk_in), .resetn_in(resetn), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .sample_valid_in(sv),
        .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az), .per_axis_ths_en_in(pae),
        .y_ths_in(yth), .z_ths_in(zth), .full_scale_select_in(fs), .low_noise_in(ln),
        .any_axis_event_out(any));

    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(1'h1, a, d, q);
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.access(1'h0, a, 8'h00, q);
        chk(n, e, q);
    endtask

    task automatic cany(input logic e);
        chk("any_axis_event", {7'h00, e}, {7'h00, any});
    endtask

    // One sample pulse; the summary flag is settled two edges later.
    task automatic samp(input logic signed [13:0] x, input logic signed [13:0] y, input logic signed [13:0] z);
        @(negedge mclk_in);
        sv <= 1'h1;
        ax <= x;
        ay <= y;
        az <= z;
        @(negedge mclk_in);
        sv <= 1'h0;
        ax <= ~x;
        ay <= ~y;
        az <= ~z;
        repeat (2) @(negedge mclk_in);
    endtask

    task automatic t_regs();
        rdc("cfg_rst", 8'h1D, 8'h00);
        rdc("status_rst", 8'h1E, 8'h00);
        rdc("ths_rst", 8'h1F, 8'h00);
        rdc("count_rst", 8'h20, 8'h00);
        wreg(8'h1E, 8'hFF);
        rdc("status_ro", 8'h1E, 8'h00);
        rdc("unmapped", 8'h30, 8'h00);
        wreg(8'h1F, 8'hFF);
        rdc("ths_rw", 8'h1F, 8'hFF);
    endtask

    // Threshold edge at every full-scale code, code 3 behaving as 8 g.
    task automatic t_scale();
        int lim;
        wreg(8'h1F, 8'h0A);
        wreg(8'h1D, 8'h02);
        for (int i = 0; i < 4; i++) begin
            fs = tesd_fs_t'(i);
            lim = ((10 * 63 * 4096) >> (i > 2 ? 2 : i)) / 1000;
            samp(14'(lim), 14'h0000, 14'h0000);
            cany(1'h0);
            samp(14'(lim + 1), 14'h0000, 14'h0000);
            cany(1'h1);
            rdc("x_pos", 8'h1E, 8'h42);
        end
        samp(-14'sd646, 14'h0000, 14'h0000);
        rdc("x_neg", 8'h1E, 8'h43);
        rdc("x_cleared", 8'h1E, 8'h01);
    endtask

    task automatic t_noise();
        wreg(8'h1F, 8'h41);
        ln = 1'h1;
        samp(14'sd5000, 14'h0000, 14'h0000);
        cany(1'h0);
        ln = 1'h0;
        samp(14'sd5000, 14'h0000, 14'h0000);
        rdc("noise_off", 8'h1E, 8'h42);
    endtask

    task automatic t_axes();
        wreg(8'h1F, 8'h0A);
        samp(14'h0000, 14'sd3000, -14'sd3000);
        cany(1'h0);
        wreg(8'h1D, 8'h0E);
        yth = 7'h02;
        zth = 7'h7F;
        samp(14'h0000, 14'sd130, 14'h0000);
        cany(1'h0);
        pae = 1'h1;
        samp(14'h0000, 14'sd130, -14'sd3000);
        rdc("y_own_ths", 8'h1E, 8'h48);
        pae = 1'h0;
        samp(14'h0000, 14'h0000, -14'sd3000);
        rdc("z_neg", 8'h1E, 8'h70);
    endtask

    // Eight samples, one bit each from the top; only the last may fire.
    task automatic dbn(input logic [7:0] ths, input logic [7:0] pat, input logic fire);
        wreg(8'h1F, ths);
        for (int i = 7; i >= 0; i--) begin
            samp(pat[i] ? 14'sd700 : 14'sd0, 14'h0000, 14'h0000);
            cany(i == 0 ? fire : 1'h0);
        end
        // The Z direction bit still holds the negative event of the axis test.
        rdc("dbn_status", 8'h1E, fire ? 8'h52 : 8'h10);
    endtask

    task automatic t_latch();
        wreg(8'h1F, 8'h0A);
        wreg(8'h1D, 8'h1A);
        samp(14'sd646, 14'h0000, 14'h0000);
        samp(-14'sd646, 14'h0000, 14'sd700);
        rdc("latched", 8'h1E, 8'h52);
        wreg(8'h1D, 8'h0A);
        samp(14'sd646, 14'h0000, 14'h0000);
        samp(-14'sd646, 14'h0000, 14'sd700);
        rdc("unlatched", 8'h1E, 8'h63);
    endtask

    initial begin
        repeat (10) @(negedge mclk_in);
        resetn = 1'h1;
        repeat (4) @(negedge mclk_in);
        t_regs();
        t_scale();
        t_noise();
        t_axes();
        wreg(8'h1D, 8'h02);
        wreg(8'h20, 8'h03);
        dbn(8'h0A, 8'h1B, 1'h1);
        dbn(8'h8A, 8'h1B, 1'h0);
        dbn(8'h8A, 8'h07, 1'h1);
        wreg(8'h20, 8'h00);
        t_latch();
        give_verdict();
    end
endmodule

`default_nettype wire

//--- verification/tesd_chk_sva.sv
// Checker for the register port and summary flag of the transient event block.
`timescale 1ns/1ps
`default_nettype none

module tesd_chk (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       sample_valid_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic       any_axis_event_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    wire logic st_rd = reg_rd_in && (reg_addr_in == 8'h1E);
    wire logic bad_rd = reg_rd_in && ((reg_addr_in < 8'h1D) || (reg_addr_in > 8'h20));

    AST_RDATA_HOLD: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    AST_TOP_BIT: assert property (st_rd |=> !reg_rdata_out[7])
        else $error("status bit 7 read as one");
    AST_SUMMARY_READ: assert property (st_rd |=> reg_rdata_out[6] == $past(any_axis_event_out))
        else $error("status bit 6 differs from summary output");
    AST_SUMMARY_FLAGS: assert property (st_rd |=> reg_rdata_out[6] == (reg_rdata_out[5] | reg_rdata_out[3] | reg_rdata_out[1]))
        else $error("summary bit disagrees with axis flags");
    AST_UNMAPPED: assert property (bad_rd |=> reg_rdata_out == 8'h00)
        else $error("unmapped read returned nonzero");
    AST_RISE_CAUSE: assert property ($rose(any_axis_event_out) |-> $past(sample_valid_in, 2))
        else $error("summary rose without a sample two cycles before");
    AST_FALL_CAUSE: assert property ($fell(any_axis_event_out) |-> $past(st_rd))
        else $error("summary fell without a status read");
    AST_READ_CLEARS: assert property (st_rd && !$past(sample_valid_in) |=> !any_axis_event_out)
        else $error("status read did not clear the flags");
endmodule

bind tesd_top tesd_chk u_chk (
    .mclk_in            (mclk_in),
    .resetn_in          (resetn_in),
    .reg_addr_in        (reg_addr_in),
    .reg_rd_in          (reg_rd_in),
    .sample_valid_in    (sample_valid_in),
    .reg_rdata_out      (reg_rdata_out),
    .any_axis_event_out (any_axis_event_out)
);

`default_nettype wire

//--- verification/tesd_host.sv
// Host model that reaches the block's registers one byte at a time.
`timescale 1ns/1ps
`default_nettype none

module tesd_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic [7:0]      addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic [7:0]      wdata_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'h0;
        rd_out = 1'h0;
        wdata_out = 8'h00;
    end

    // A released bus shows the inverse of the last value so stale data never matches.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_in);
        addr_out <= a;
        wr_out <= w;
        rd_out <= !w;
        wdata_out <= d;
        @(negedge clk_in);
        wr_out <= 1'h0;
        rd_out <= 1'h0;
        addr_out <= ~a;
        wdata_out <= ~d;
        @(negedge clk_in);
        q = rdata_in;
    endtask
endmodule

`default_nettype wire
